/* tb.sv */
`timescale 1ns/1ps
module tb;
    logic        clk_i = 1'b0, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic        rx_pin_oe_o, tx_pin_o, irq_o, line;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, cap = 32'h0;
    int          err_count = 0, n_tests = 0;
    unbf_uart DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .rx_pin_i(line & ~rx_pin_oe_o), .rx_pin_o(), .rx_pin_oe_o, .tx_pin_o, .irq_o);
    unbf_node node (.clk_i, .line_o(line));
    initial forever #20 clk_i = ~clk_i;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        err_count += int'(got !== exp);
        if (got !== exp) $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
    endtask
    task automatic complete_run(input bit hang);
        err_count += int'(hang);
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++k < 20);
        if (wb_ack_o !== 1'b1) complete_run(1'b1);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(wb_dat_o, exp);
    endtask
    task automatic capture(input int nb);
        repeat (8) @(posedge clk_i);
        for (int k = 0; k < nb; k++) begin
            repeat (16) @(posedge clk_i);
            cap[k] = tx_pin_o;
        end
    endtask
    // long idle first so a stray frame after a bad stop bit has ended
    task automatic rx(input logic [31:0] c, st, d, ec, input int nb, input logic [10:0] f);
        repeat (200) @(posedge clk_i);
        wb(1'b1, 8'h10, 32'h3);
        wb(1'b1, 8'h00, c);
        node.send(nb, f);
        rdchk(8'h10, st);
        rdchk(8'h04, d);
        rdchk(8'h00, ec);
        chk({31'h0, irq_o}, {31'h0, st[1]});
    endtask
    initial begin
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = {1'b1, 43'h0, 4'hF};
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk(8'h20, 32'h0);
        wb(1'b1, 8'h0C, 32'h10);
        wb(1'b1, 8'h00, 32'h1);
        wb(1'b1, 8'h04, 32'hA5);
        capture(9);
        chk(cap, 32'h1A5);
        chk({31'h0, irq_o}, 32'h0);
        wb(1'b1, 8'h14, 32'h3);
        rdchk(8'h10, 32'h1);
        chk({31'h0, irq_o}, 32'h1);
        wb(1'b1, 8'h10, 32'h1);
        wb(1'b1, 8'h00, 32'h13);
        wb(1'b1, 8'h04, 32'h3C);
        capture(9);
        chk(cap, 32'h13C);
        $display("test transmit done");
        rx(32'h01, 32'h0, 32'h0, 32'h01, 10, 11'h2B4);
        rx(32'h09, 32'h2, 32'h5A, 32'h29, 10, 11'h2B4);
        rx(32'h0D, 32'h0, 32'h5A, 32'h2D, 10, 11'h0B4);
        rx(32'h0B, 32'h2, 32'h77, 32'h0B, 11, 11'h4EE);
        rx(32'h0F, 32'h0, 32'h77, 32'h0F, 11, 11'h684);
        rx(32'h0F, 32'h2, 32'hFF, 32'h2F, 11, 11'h7FE);
        $display("test receive done");
        wb(1'b1, 8'h10, 32'h3);
        wb(1'b1, 8'h00, 32'h0);
        wb(1'b1, 8'h04, 32'h96);
        for (int k = 0; k < 8; k++) begin
            repeat (k == 0 ? 6 : 12) @(posedge clk_i);
            cap[k] = ~rx_pin_oe_o;
        end
        chk({24'h0, cap[7:0]}, 32'h96);
        repeat (20) @(posedge clk_i);
        rdchk(8'h10, 32'h1);
        wb(1'b1, 8'h10, 32'h3);
        node.line_o <= 1'b0;
        wb(1'b1, 8'h00, 32'h08);
        repeat (110) @(posedge clk_i);
        rdchk(8'h10, 32'h2);
        rdchk(8'h04, 32'h0);
        rdchk(8'h00, 32'h28);
        node.line_o <= 1'b1;
        $display("test mode 0 done");
        complete_run(1'b0);
    end
endmodule

/* unbf_bit_tick.sv */
`timescale 1ns/1ps
module unbf_bit_tick (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [15:0] period_i,
    input  wire logic        restart_i,
    input  wire logic        half_i,
    output logic             tick_o
);
    logic [15:0] cnt_reg;

    // half load puts receive sampling at mid-bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= 16'h0000;
        end else if (restart_i) begin
            cnt_reg <= half_i ? (period_i >> 1) : (period_i - 16'h0001);
        end else if (cnt_reg == 16'h0000) begin
            cnt_reg <= period_i - 16'h0001;
        end else begin
            cnt_reg <= cnt_reg - 16'h0001;
        end
    end

    assign tick_o = (cnt_reg == 16'h0000) && !restart_i;
endmodule

/* unbf_defs.svh */
`ifndef UNBF_DEFS_SVH
`define UNBF_DEFS_SVH

// register byte offsets, one aligned word each
`define UNBF_ADR_CTRL   8'h00
`define UNBF_ADR_DATA   8'h04
`define UNBF_ADR_ADDR   8'h08
`define UNBF_ADR_BAUD   8'h0C
`define UNBF_ADR_STAT   8'h10
`define UNBF_ADR_MASK   8'h14
`define UNBF_UNMAPPED   32'h0000_0000

// field widths and byte lanes
`define UNBF_CTRL_W     6
`define UNBF_IRQ_W      2
`define UNBF_LANE0      7:0
`define UNBF_LANE1      15:8

// reset values
`define UNBF_CTRL_RST   6'h00
`define UNBF_IRQ_RST    2'h0
`define UNBF_BAUD_RST   16'h00D9
`define UNBF_OWN_RST    8'h00
`define UNBF_BCAST_RST  8'hFF
`define UNBF_BYTE_RST   8'h00
`define UNBF_CNT_RST    3'h0

// timing, in system clocks, and bit counter last index and step
`define UNBF_M0_HALF    16'h0006
`define UNBF_M2_BIT     16'h0020
`define UNBF_LAST_BIT   3'h7
`define UNBF_CNT_STEP   3'h1

`endif

/* unbf_node.sv */
`timescale 1ns/1ps
module unbf_node (
    input  wire logic clk_i,
    output logic      line_o
);
    initial line_o = 1'b1;
    task automatic send(input int nb, input logic [10:0] f);
        for (int k = 0; k <= nb; k++) begin
            @(posedge clk_i);
            line_o <= (k == nb) ? 1'b1 : f[k];
            repeat (15) @(posedge clk_i);
        end
    endtask
endmodule

/* unbf_pkg.sv */
package unbf_pkg;

    typedef enum logic [1:0] {
        UNBF_MODE0 = 2'b00,
        UNBF_MODE1 = 2'b01,
        UNBF_MODE2 = 2'b10,
        UNBF_MODE3 = 2'b11
    } unbf_mode_t;

    typedef struct packed {
        logic       rx_ninth_bit;
        logic       tx_ninth_bit;
        logic       rx_enable_bit;
        logic       multiproc_stop_check_bit;
        unbf_mode_t mode;
    } unbf_ctrl_t;

    typedef struct packed {
        logic [7:0] bcast;
        logic [7:0] own;
    } unbf_addr_t;

    typedef struct packed {
        logic rx_done_flag;
        logic tx_done_flag;
    } unbf_irq_t;

    typedef enum logic [2:0] {
        UNBF_TX_IDLE  = 3'b000,
        UNBF_TX_START = 3'b001,
        UNBF_TX_DATA  = 3'b010,
        UNBF_TX_NINTH = 3'b011,
        UNBF_TX_STOP  = 3'b100,
        UNBF_TX_SYNC  = 3'b101
    } unbf_tx_state_t;

    typedef enum logic [2:0] {
        UNBF_RX_IDLE  = 3'b000,
        UNBF_RX_START = 3'b001,
        UNBF_RX_DATA  = 3'b010,
        UNBF_RX_NINTH = 3'b011,
        UNBF_RX_STOP  = 3'b100
    } unbf_rx_state_t;

endpackage

/* unbf_uart.sv */
`timescale 1ns/1ps
`include "unbf_defs.svh"
// Notes on behaviour
// - frames are taken in only while the receive enable bit is one in modes 1 to 3; mode 0 checks it only when a reception starts.
// - in modes 2 and 3 the ninth transmitted bit carries the live level of the ninth tx bit.
// - the ninth tx bit is unused in modes 0 and 1 and only software writes change it.
// - in modes 2 and 3 an accepted frame loads its ninth bit into the ninth rx bit.
// - in mode 1 with stop check off the received stop bit is loaded into the ninth rx bit.
// - mode 0 reception never touches the ninth rx bit.
// - tx done sets after the eighth bit in mode 0, else at the start of the stop bit.
// - a set tx done flag raises the interrupt when its mask bit enables it.
// - tx done stays set until software clears it; hardware never clears it.
// - in mode 1 with stop check on, rx done sets only if the stop bit is one.
// - in modes 2 and 3 with multiprocessor enable, rx done needs ninth bit one and an address hit.
module unbf_uart (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        rx_pin_i,
    output logic             rx_pin_o,
    output logic             rx_pin_oe_o,
    output logic             tx_pin_o,
    output logic             irq_o
);
    unbf_pkg::unbf_ctrl_t     ctrl_reg;
    unbf_pkg::unbf_addr_t     addr_reg;
    unbf_pkg::unbf_irq_t      stat_reg;
    unbf_pkg::unbf_irq_t      mask_reg;
    unbf_pkg::unbf_irq_t      wr_irq;
    unbf_pkg::unbf_ctrl_t     wr_ctrl_val;
    unbf_pkg::unbf_tx_state_t tx_state_reg;
    unbf_pkg::unbf_rx_state_t rx_state_reg;
    logic [15:0]              baud_reg;
    logic [7:0]               rx_data_reg;
    logic [7:0]               tx_shift_reg;
    logic [7:0]               rx_shift_reg;
    logic [2:0]               tx_cnt_reg;
    logic [2:0]               rx_cnt_reg;
    logic                     tx_phase_reg;
    logic                     m0_rx_reg;
    logic                     rx_bit9_reg;
    logic                     rx_prev_reg;
    logic                     ack_reg;
    logic [31:0]              dat_reg;
    logic                     irq_reg;
    logic                     tx_pin_reg;
    logic                     od_oe_reg;
    logic                     tx_tick;
    logic                     rx_tick;
    logic                     wb_req;
    logic                     wr_fire;
    logic                     wr_ctrl;
    logic                     wr_data;
    logic                     wr_addr;
    logic                     wr_baud;
    logic                     wr_stat;
    logic                     wr_mask;
    logic                     tx_go;
    logic                     m0_rx_go;
    logic                     rx_go;
    logic                     m0_last;
    logic                     tx_set;
    logic                     m0_rx_set;
    logic                     rx_stop_tick;
    logic                     addr_hit;
    logic                     frame_ok;
    logic                     accept;
    logic                     rx_set;

    function automatic logic [15:0] bit_period(input unbf_pkg::unbf_mode_t m,
                                               input logic [15:0] b);
        case (m)
            unbf_pkg::UNBF_MODE0: bit_period = `UNBF_M0_HALF;
            unbf_pkg::UNBF_MODE2: bit_period = `UNBF_M2_BIT;
            default:              bit_period = b;
        endcase
    endfunction

    function automatic logic nine_bit(input unbf_pkg::unbf_mode_t m);
        nine_bit = (m == unbf_pkg::UNBF_MODE2) || (m == unbf_pkg::UNBF_MODE3);
    endfunction

    unbf_bit_tick u_tx_tick (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .period_i  (bit_period(ctrl_reg.mode, baud_reg)),
        .restart_i (tx_go || m0_rx_go),
        .half_i    (1'b0),
        .tick_o    (tx_tick)
    );

    unbf_bit_tick u_rx_tick (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .period_i  (bit_period(ctrl_reg.mode, baud_reg)),
        .restart_i (rx_go),
        .half_i    (1'b1),
        .tick_o    (rx_tick)
    );

    // wishbone: ack one cycle after the strobe, writes land at the ack edge
    assign wb_req  = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
    assign wr_ctrl = wr_fire && (wb_adr_i == `UNBF_ADR_CTRL) && wb_sel_i[0];
    assign wr_data = wr_fire && (wb_adr_i == `UNBF_ADR_DATA) && wb_sel_i[0];
    assign wr_addr = wr_fire && (wb_adr_i == `UNBF_ADR_ADDR);
    assign wr_baud = wr_fire && (wb_adr_i == `UNBF_ADR_BAUD);
    assign wr_stat = wr_fire && (wb_adr_i == `UNBF_ADR_STAT) && wb_sel_i[0];
    assign wr_mask = wr_fire && (wb_adr_i == `UNBF_ADR_MASK) && wb_sel_i[0];
    assign wr_irq  = unbf_pkg::unbf_irq_t'(wb_dat_i[`UNBF_IRQ_W-1:0]);
    // named so fields are picked from a plain variable, not from a cast
    assign wr_ctrl_val = unbf_pkg::unbf_ctrl_t'(wb_dat_i[`UNBF_CTRL_W-1:0]);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= `UNBF_UNMAPPED;
        end else begin
            ack_reg <= wb_req;
            if (wb_req) begin
                case (wb_adr_i)
                    `UNBF_ADR_CTRL: dat_reg <= 32'(ctrl_reg);
                    `UNBF_ADR_DATA: dat_reg <= 32'(rx_data_reg);
                    `UNBF_ADR_ADDR: dat_reg <= 32'(addr_reg);
                    `UNBF_ADR_BAUD: dat_reg <= 32'(baud_reg);
                    `UNBF_ADR_STAT: dat_reg <= 32'(stat_reg);
                    `UNBF_ADR_MASK: dat_reg <= 32'(mask_reg);
                    default:        dat_reg <= `UNBF_UNMAPPED;
                endcase
            end
        end
    end

    // software-owned configuration; rx ninth bit is hardware-owned
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= unbf_pkg::unbf_ctrl_t'(`UNBF_CTRL_RST);
        end else begin
            if (wr_ctrl) begin
                // rx ninth bit is left out: software cannot write it
                ctrl_reg.mode                     <= wr_ctrl_val.mode;
                ctrl_reg.multiproc_stop_check_bit <= wr_ctrl_val.multiproc_stop_check_bit;
                ctrl_reg.rx_enable_bit            <= wr_ctrl_val.rx_enable_bit;
                ctrl_reg.tx_ninth_bit             <= wr_ctrl_val.tx_ninth_bit;
            end
            if (accept && (ctrl_reg.mode == unbf_pkg::UNBF_MODE1)) begin
                ctrl_reg.rx_ninth_bit <= rx_pin_i;
            end else if (accept) begin
                ctrl_reg.rx_ninth_bit <= rx_bit9_reg;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_reg <= {`UNBF_BCAST_RST, `UNBF_OWN_RST};
            baud_reg <= `UNBF_BAUD_RST;
        end else begin
            if (wr_addr && wb_sel_i[0]) addr_reg[`UNBF_LANE0] <= wb_dat_i[`UNBF_LANE0];
            if (wr_addr && wb_sel_i[1]) addr_reg[`UNBF_LANE1] <= wb_dat_i[`UNBF_LANE1];
            if (wr_baud && wb_sel_i[0]) baud_reg[`UNBF_LANE0] <= wb_dat_i[`UNBF_LANE0];
            if (wr_baud && wb_sel_i[1]) baud_reg[`UNBF_LANE1] <= wb_dat_i[`UNBF_LANE1];
        end
    end

    // sticky flags: a set in the clearing cycle wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_reg <= `UNBF_IRQ_RST;
            mask_reg <= `UNBF_IRQ_RST;
            irq_reg  <= 1'b0;
        end else begin
            stat_reg.tx_done_flag <= tx_set ||
                (stat_reg.tx_done_flag && !(wr_stat && wr_irq.tx_done_flag));
            stat_reg.rx_done_flag <= rx_set ||
                (stat_reg.rx_done_flag && !(wr_stat && wr_irq.rx_done_flag));
            if (wr_mask) mask_reg <= wr_irq;
            irq_reg <= |(stat_reg & mask_reg);
        end
    end

    // transmit engine; in mode 0 it also clocks half-duplex reception
    assign tx_go    = wr_data && (tx_state_reg == unbf_pkg::UNBF_TX_IDLE);
    assign m0_rx_go = (tx_state_reg == unbf_pkg::UNBF_TX_IDLE) && !wr_data &&
                      (ctrl_reg.mode == unbf_pkg::UNBF_MODE0) &&
                      ctrl_reg.rx_enable_bit && !stat_reg.rx_done_flag;
    assign m0_last  = (tx_state_reg == unbf_pkg::UNBF_TX_SYNC) && tx_tick &&
                      tx_phase_reg && (tx_cnt_reg == `UNBF_LAST_BIT);
    assign tx_set   = (m0_last && !m0_rx_reg) || (tx_tick && (
                      (tx_state_reg == unbf_pkg::UNBF_TX_NINTH) ||
                      ((tx_state_reg == unbf_pkg::UNBF_TX_DATA) &&
                       (tx_cnt_reg == `UNBF_LAST_BIT) && !nine_bit(ctrl_reg.mode))));
    assign m0_rx_set = m0_last && m0_rx_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_state_reg <= unbf_pkg::UNBF_TX_IDLE;
            tx_shift_reg <= `UNBF_BYTE_RST;
            tx_cnt_reg   <= `UNBF_CNT_RST;
            tx_phase_reg <= 1'b0;
            m0_rx_reg    <= 1'b0;
            tx_pin_reg   <= 1'b1;
            od_oe_reg    <= 1'b0;
        end else begin
            case (tx_state_reg)
                unbf_pkg::UNBF_TX_IDLE: begin
                    tx_pin_reg <= 1'b1;
                    od_oe_reg  <= 1'b0;
                    tx_cnt_reg <= `UNBF_CNT_RST;
                    if (tx_go && (ctrl_reg.mode == unbf_pkg::UNBF_MODE0)) begin
                        tx_state_reg <= unbf_pkg::UNBF_TX_SYNC;
                        tx_shift_reg <= wb_dat_i[`UNBF_LANE0];
                        tx_phase_reg <= 1'b0;
                        m0_rx_reg    <= 1'b0;
                        tx_pin_reg   <= 1'b0;
                        od_oe_reg    <= !wb_dat_i[0];
                    end else if (tx_go) begin
                        tx_state_reg <= unbf_pkg::UNBF_TX_START;
                        tx_shift_reg <= wb_dat_i[`UNBF_LANE0];
                        tx_pin_reg   <= 1'b0;
                    end else if (m0_rx_go) begin
                        tx_state_reg <= unbf_pkg::UNBF_TX_SYNC;
                        tx_phase_reg <= 1'b0;
                        m0_rx_reg    <= 1'b1;
                        tx_pin_reg   <= 1'b0;
                    end
                end
                unbf_pkg::UNBF_TX_START: begin
                    if (tx_tick) begin
                        tx_state_reg <= unbf_pkg::UNBF_TX_DATA;
                        tx_pin_reg   <= tx_shift_reg[0];
                        tx_shift_reg <= tx_shift_reg >> 1;
                    end
                end
                unbf_pkg::UNBF_TX_DATA: begin
                    if (tx_tick && (tx_cnt_reg == `UNBF_LAST_BIT)) begin
                        if (nine_bit(ctrl_reg.mode)) begin
                            tx_state_reg <= unbf_pkg::UNBF_TX_NINTH;
                            tx_pin_reg   <= ctrl_reg.tx_ninth_bit;
                        end else begin
                            tx_state_reg <= unbf_pkg::UNBF_TX_STOP;
                            tx_pin_reg   <= 1'b1;
                        end
                    end else if (tx_tick) begin
                        tx_cnt_reg   <= tx_cnt_reg + `UNBF_CNT_STEP;
                        tx_pin_reg   <= tx_shift_reg[0];
                        tx_shift_reg <= tx_shift_reg >> 1;
                    end
                end
                unbf_pkg::UNBF_TX_NINTH: begin
                    // follows the live bit so a late software change still goes out
                    tx_pin_reg <= tx_tick ? 1'b1 : ctrl_reg.tx_ninth_bit;
                    if (tx_tick) tx_state_reg <= unbf_pkg::UNBF_TX_STOP;
                end
                unbf_pkg::UNBF_TX_STOP: begin
                    if (tx_tick) tx_state_reg <= unbf_pkg::UNBF_TX_IDLE;
                end
                unbf_pkg::UNBF_TX_SYNC: begin
                    if (tx_tick && !tx_phase_reg) begin
                        tx_pin_reg   <= 1'b1;
                        tx_phase_reg <= 1'b1;
                        if (m0_rx_reg) tx_shift_reg <= {rx_pin_i, tx_shift_reg[7:1]};
                    end else if (tx_tick && (tx_cnt_reg == `UNBF_LAST_BIT)) begin
                        tx_state_reg <= unbf_pkg::UNBF_TX_IDLE;
                        od_oe_reg    <= 1'b0;
                    end else if (tx_tick) begin
                        tx_cnt_reg   <= tx_cnt_reg + `UNBF_CNT_STEP;
                        tx_pin_reg   <= 1'b0;
                        tx_phase_reg <= 1'b0;
                        if (!m0_rx_reg) begin
                            tx_shift_reg <= tx_shift_reg >> 1;
                            od_oe_reg    <= !tx_shift_reg[1];
                        end
                    end
                end
                default: tx_state_reg <= unbf_pkg::UNBF_TX_IDLE;
            endcase
        end
    end

    // asynchronous receiver
    assign rx_go        = (rx_state_reg == unbf_pkg::UNBF_RX_IDLE) &&
                          (ctrl_reg.mode != unbf_pkg::UNBF_MODE0) &&
                          ctrl_reg.rx_enable_bit && rx_prev_reg && !rx_pin_i;
    assign rx_stop_tick = (rx_state_reg == unbf_pkg::UNBF_RX_STOP) && rx_tick;
    assign addr_hit     = (rx_shift_reg == addr_reg.own) || (rx_shift_reg == addr_reg.bcast);
    assign frame_ok     = (ctrl_reg.mode == unbf_pkg::UNBF_MODE1) ?
                          (!ctrl_reg.multiproc_stop_check_bit || rx_pin_i) :
                          (!ctrl_reg.multiproc_stop_check_bit ||
                           (rx_bit9_reg && addr_hit));
    assign accept       = rx_stop_tick && ctrl_reg.rx_enable_bit &&
                          !stat_reg.rx_done_flag && frame_ok;
    assign rx_set       = accept || m0_rx_set;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_data_reg <= `UNBF_BYTE_RST;
        end else if (accept) begin
            rx_data_reg <= rx_shift_reg;
        end else if (m0_rx_set) begin
            rx_data_reg <= tx_shift_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_state_reg <= unbf_pkg::UNBF_RX_IDLE;
            rx_shift_reg <= `UNBF_BYTE_RST;
            rx_cnt_reg   <= `UNBF_CNT_RST;
            rx_bit9_reg  <= 1'b0;
            rx_prev_reg  <= 1'b1;
        end else begin
            rx_prev_reg <= rx_pin_i;
            if (!ctrl_reg.rx_enable_bit) begin
                rx_state_reg <= unbf_pkg::UNBF_RX_IDLE;
            end else begin
                case (rx_state_reg)
                    unbf_pkg::UNBF_RX_IDLE: begin
                        rx_cnt_reg <= `UNBF_CNT_RST;
                        if (rx_go) rx_state_reg <= unbf_pkg::UNBF_RX_START;
                    end
                    unbf_pkg::UNBF_RX_START: begin
                        // a glitch shorter than half a bit is dropped here
                        if (rx_tick) rx_state_reg <= rx_pin_i ? unbf_pkg::UNBF_RX_IDLE
                                                              : unbf_pkg::UNBF_RX_DATA;
                    end
                    unbf_pkg::UNBF_RX_DATA: begin
                        if (rx_tick) begin
                            rx_shift_reg <= {rx_pin_i, rx_shift_reg[7:1]};
                            rx_cnt_reg   <= rx_cnt_reg + `UNBF_CNT_STEP;
                            if (rx_cnt_reg == `UNBF_LAST_BIT) begin
                                rx_state_reg <= nine_bit(ctrl_reg.mode) ?
                                    unbf_pkg::UNBF_RX_NINTH : unbf_pkg::UNBF_RX_STOP;
                            end
                        end
                    end
                    unbf_pkg::UNBF_RX_NINTH: begin
                        if (rx_tick) begin
                            rx_bit9_reg  <= rx_pin_i;
                            rx_state_reg <= unbf_pkg::UNBF_RX_STOP;
                        end
                    end
                    unbf_pkg::UNBF_RX_STOP: begin
                        if (rx_tick) rx_state_reg <= unbf_pkg::UNBF_RX_IDLE;
                    end
                    default: rx_state_reg <= unbf_pkg::UNBF_RX_IDLE;
                endcase
            end
        end
    end

    assign wb_ack_o    = ack_reg;
    assign wb_dat_o    = dat_reg;
    assign irq_o       = irq_reg;
    assign tx_pin_o    = tx_pin_reg;
    assign rx_pin_o    = 1'b0;
    assign rx_pin_oe_o = od_oe_reg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_stop_entry;
        tx_tick && (tx_state_reg == unbf_pkg::UNBF_TX_NINTH);
    endsequence
    sequence s_flag_up;
        stat_reg.tx_done_flag && (tx_state_reg == unbf_pkg::UNBF_TX_STOP);
    endsequence

    AST_RX_ONLY_ENABLED: assert property (
        $rose(stat_reg.rx_done_flag) |-> $past(ctrl_reg.rx_enable_bit))
        else $error("rx done set while receiver disabled");
    AST_TX_NINTH_LEVEL: assert property (
        (tx_state_reg == unbf_pkg::UNBF_TX_NINTH) && $past(tx_state_reg ==
        unbf_pkg::UNBF_TX_NINTH) && !$past(tx_tick) |-> tx_pin_o == $past(ctrl_reg.tx_ninth_bit))
        else $error("ninth tx bit level wrong");
    AST_TX_NINTH_SW: assert property (
        !$stable(ctrl_reg.tx_ninth_bit) |-> $past(wr_ctrl))
        else $error("ninth tx bit changed without a write");
    AST_RX_NINTH_M23: assert property (
        accept && nine_bit(ctrl_reg.mode) |=> ctrl_reg.rx_ninth_bit == $past(rx_bit9_reg))
        else $error("ninth rx bit not loaded");
    AST_RX_NINTH_M1: assert property (
        accept && (ctrl_reg.mode == unbf_pkg::UNBF_MODE1) |=>
        ctrl_reg.rx_ninth_bit == $past(rx_pin_i))
        else $error("stop bit not loaded");
    AST_RX_NINTH_M0: assert property (
        m0_rx_set |=> $stable(ctrl_reg.rx_ninth_bit) && stat_reg.rx_done_flag)
        else $error("mode 0 touched ninth rx bit");
    AST_TX_DONE_AT_STOP: assert property (
        s_stop_entry |=> s_flag_up)
        else $error("tx done not set at stop bit");
    AST_TX_IRQ: assert property (
        $rose(stat_reg.tx_done_flag) && mask_reg.tx_done_flag |=> irq_o)
        else $error("interrupt not raised");
    AST_TX_STICKY: assert property (
        stat_reg.tx_done_flag && !(wr_stat && wr_irq.tx_done_flag) |=> stat_reg.tx_done_flag)
        else $error("tx done cleared by hardware");
    AST_RX_STICKY: assert property (
        stat_reg.rx_done_flag && !(wr_stat && wr_irq.rx_done_flag) |=> stat_reg.rx_done_flag)
        else $error("rx done cleared by hardware");
    AST_M1_STOP_CHECK: assert property (
        rx_stop_tick && (ctrl_reg.mode == unbf_pkg::UNBF_MODE1) &&
        ctrl_reg.multiproc_stop_check_bit && !rx_pin_i |-> !accept)
        else $error("bad stop bit accepted");
    AST_MP_ADDRESS: assert property (
        accept && nine_bit(ctrl_reg.mode) && ctrl_reg.multiproc_stop_check_bit |->
        rx_bit9_reg && addr_hit)
        else $error("multiprocessor filter bypassed");
endmodule
